// >>> sli_pkg.sv
// Package: constants and types for the status LED / buzzer indicator
package sli_pkg;

  // Operating state from power control
  typedef enum logic [2:0] {
    SLI_ST_STANDBY  = 3'h0,
    SLI_ST_TRANSFER = 3'h1,
    SLI_ST_COMPLETE = 3'h2,
    SLI_ST_FAULT    = 3'h3,
    SLI_ST_FOA_WARN = 3'h4
  } sli_op_state_t;

  // Indicator outputs carried together
  typedef struct packed {
    logic green_led_output;
    logic red_led_output;
    logic buzzer_output;
  } sli_ind_t;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TONE_HZ         = 2_000;
  localparam int unsigned TONE_HALF_CYC   = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned MS_CYC          = CLK_HZ / 1_000;

  // Times in milliseconds
  localparam int unsigned NOTE_TONE_MS    = 400;
  localparam int unsigned NOTE_LATENCY_MS = 500;
  localparam int unsigned FOA_ON_MS       = 400;
  localparam int unsigned FOA_OFF_MS      = 800;
  localparam int unsigned FOA_PHASE_MS    = 30_000;
  // Slow period kept above the 1.2 s warning period so fast stays faster
  localparam int unsigned SLOW_PERIOD_MS  = 2_000;
  localparam int unsigned SLOW_ON_MS      = 1_000;
  localparam int unsigned SLOW_DUTY_DIV   = SLOW_PERIOD_MS / SLOW_ON_MS;
  localparam int unsigned FOA_DUTY_DIV    = (FOA_ON_MS + FOA_OFF_MS) / FOA_ON_MS;

  // Option decode
  localparam logic [3:0]  OPT_FIRST_DARK  = 4'h6;
  localparam logic [3:0]  OPT_MAX         = 4'hA;
  localparam logic [3:0]  OPT_PULL_DOWN   = 4'h1;
  localparam logic [3:0]  OPT_PULL_UP     = 4'h6;
  localparam logic [3:0]  LVL_PULL_UP     = 4'h5;
  localparam logic [3:0]  LVL_LAST        = 4'h9;

  localparam sli_ind_t    IND_RESET       = '{1'b0, 1'b0, 1'b0};

endpackage

// >>> sli_indicator.sv
// Status LED and buzzer indicator for the power transmitter
// Behaviour
// R1 - Green LED output shows standby, transfer and complete states.
// R2 - Red LED output shows standby, fault and foreign-object warning states.
// R3 - Green blinks slow in transfer, on at complete, off in fault/warning.
// R4 - Red off in transfer/complete, on in fault, blinks fast in warning.
// R5 - After power-up show standby pattern until another state arrives.
// R6 - Options 1 to 5 light both LEDs during standby.
// R7 - Options 6 to 10 keep both LEDs dark during standby.
// R8 - Strap: pull-down option 1, levels give 2-5, pull-up 6, then 7-10.
// R9 - Strap sampled once at power-on; option latched afterwards.
// R10 - Reserved options behave as their standby group; two fully supported.
// R11 - Tone is buzzer output toggled at 2 kHz.
// R12 - Entering transfer sounds one 400 ms tone.
// R13 - Transfer tone starts within 500 ms of entering transfer.
// R14 - Transfer tone starts within 250 ms of the LED change.
// R15 - Warning: 400 ms on, 800 ms off for 30 s, then 30 s silent.
// R16 - Warning tones track red LED; LED keeps blinking while silent.
// R17 - Blink periods and duty are parameters; fast shorter than slow.
// R18 - Operating state is an encoded input; outputs follow within one clock.
`timescale 1ns/100ps
module sli_indicator #(
  parameter int unsigned SLOW_PERIOD_CYC = sli_pkg::SLOW_PERIOD_MS * sli_pkg::MS_CYC,
  parameter int unsigned SLOW_ON_CYC     = SLOW_PERIOD_CYC / sli_pkg::SLOW_DUTY_DIV,
  parameter int unsigned NOTE_CYC        = sli_pkg::NOTE_TONE_MS * sli_pkg::MS_CYC,
  parameter int unsigned FOA_PERIOD_CYC  = (sli_pkg::FOA_ON_MS + sli_pkg::FOA_OFF_MS) * sli_pkg::MS_CYC,
  parameter int unsigned FOA_ON_CYC      = FOA_PERIOD_CYC / sli_pkg::FOA_DUTY_DIV,
  parameter int unsigned FOA_PHASES      = sli_pkg::FOA_PHASE_MS / (sli_pkg::FOA_ON_MS + sli_pkg::FOA_OFF_MS),
  parameter int unsigned TONE_HALF_CYC   = sli_pkg::TONE_HALF_CYC
) (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire sli_pkg::sli_op_state_t op_state_i,
  input  wire logic [3:0]            strap_level_i,
  output logic                       green_led_output_o,
  output logic                       red_led_output_o,
  output logic                       buzzer_output_o,
  output logic [3:0]                 led_option_o
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Caught on the first clock after reset release, never again
  logic       opt_valid;
  logic [3:0] option;
  logic       next_opt_valid;
  logic [3:0] next_option;

  always_comb begin
    next_opt_valid = opt_valid;
    next_option    = option;
    if (!opt_valid) begin // R9
      next_opt_valid = 1'b1;
      if (strap_level_i > sli_pkg::LVL_LAST) begin // R8
        // Unused codes clamp to the last option rather than alias a lit one
        next_option = sli_pkg::OPT_MAX;
      end else if (strap_level_i >= sli_pkg::LVL_PULL_UP) begin // R8
        next_option = sli_pkg::OPT_PULL_UP + (strap_level_i - sli_pkg::LVL_PULL_UP);
      end else begin // R8
        next_option = sli_pkg::OPT_PULL_DOWN + strap_level_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      opt_valid <= 1'b0;
      option    <= sli_pkg::OPT_PULL_DOWN;
    end else begin
      opt_valid <= next_opt_valid;
      option    <= next_option;
    end
  end

  // Pull-up group and above keep standby dark
  logic standby_lit;
  assign standby_lit = (option < sli_pkg::OPT_FIRST_DARK); // R6 R7 R10

  // ----------------------------------------------------------------
  // Blink and tone timers
  // ----------------------------------------------------------------
  localparam int unsigned FAST_PERIOD_CYC = FOA_PERIOD_CYC; // R17
  localparam int unsigned CW = $clog2(SLOW_PERIOD_CYC > FOA_PERIOD_CYC ? SLOW_PERIOD_CYC : FOA_PERIOD_CYC) + 1;
  localparam int unsigned NW = $clog2(NOTE_CYC) + 1;
  localparam int unsigned TW = $clog2(TONE_HALF_CYC) + 1;
  localparam int unsigned PW = $clog2(FOA_PHASES) + 2;

  sli_pkg::sli_op_state_t prev_state;
  sli_pkg::sli_op_state_t next_prev_state;
  logic                   changed;

  always_comb begin
    next_prev_state = op_state_i;
    changed         = (op_state_i != prev_state);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prev_state <= sli_pkg::SLI_ST_STANDBY;
    end else begin
      prev_state <= next_prev_state;
    end
  end

  // Counters restart on state entry so LEDs and tone start together
  logic [CW-1:0] next_slow_cnt;
  logic [CW-1:0] next_fast_cnt;
  logic          fast_wrap;

  sli_wrap_cnt #(
    .PERIOD (SLOW_PERIOD_CYC),
    .W      (CW)
  ) slow_u (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .clear_i (changed), // R14
    .run_i   (1'b1),
    .next_o  (next_slow_cnt),
    .wrap_o  ()
  );

  sli_wrap_cnt #(
    .PERIOD (FAST_PERIOD_CYC),
    .W      (CW)
  ) fast_u (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .clear_i (changed), // R16
    .run_i   (1'b1),
    .next_o  (next_fast_cnt),
    .wrap_o  (fast_wrap)
  );

  // Warning half-minute phases
  logic [PW-1:0] phase_cnt;
  logic [PW-1:0] next_phase_cnt;
  logic          silent_half;
  logic          next_silent_half;

  always_comb begin
    next_phase_cnt   = phase_cnt;
    next_silent_half = silent_half;
    if (changed) begin // R16
      next_phase_cnt   = '0;
      next_silent_half = 1'b0;
    end else if (fast_wrap) begin // R15
      if (phase_cnt == PW'(FOA_PHASES - 1)) begin
        next_phase_cnt   = '0;
        next_silent_half = ~silent_half;
      end else begin
        next_phase_cnt = phase_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt   <= '0;
      silent_half <= 1'b0;
    end else begin
      phase_cnt   <= next_phase_cnt;
      silent_half <= next_silent_half;
    end
  end

  // Transfer notification length
  logic [NW-1:0] note_cnt;
  logic [NW-1:0] next_note_cnt;

  always_comb begin
    next_note_cnt = note_cnt;
    if (changed && op_state_i == sli_pkg::SLI_ST_TRANSFER) begin // R12 R13
      next_note_cnt = NW'(NOTE_CYC);
    end else if (op_state_i != sli_pkg::SLI_ST_TRANSFER) begin
      next_note_cnt = '0;
    end else if (note_cnt != '0) begin
      next_note_cnt = note_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      note_cnt <= '0;
    end else begin
      note_cnt <= next_note_cnt;
    end
  end

  // 2 kHz square wave while a tone is wanted
  logic slow_on;
  logic fast_on;
  logic beep;
  logic tone_flip;
  logic tone_lvl;
  logic next_tone_lvl;

  always_comb begin
    slow_on = (next_slow_cnt < CW'(SLOW_ON_CYC)); // R17
    fast_on = (next_fast_cnt < CW'(FOA_ON_CYC)); // R17
    beep    = (next_note_cnt != '0) ||
              (op_state_i == sli_pkg::SLI_ST_FOA_WARN && fast_on && !next_silent_half); // R15 R16
  end

  // Held clear between tones, so every tone opens with a low half
  sli_wrap_cnt #(
    .PERIOD (TONE_HALF_CYC),
    .W      (TW)
  ) tone_u (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .clear_i (!beep),
    .run_i   (beep),
    .next_o  (),
    .wrap_o  (tone_flip)
  );

  always_comb begin
    next_tone_lvl = 1'b0;
    if (beep) begin // R11
      next_tone_lvl = tone_lvl ^ tone_flip;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tone_lvl <= 1'b0;
    end else begin
      tone_lvl <= next_tone_lvl;
    end
  end

  // ----------------------------------------------------------------
  // Output pattern
  // ----------------------------------------------------------------
  sli_pkg::sli_ind_t ind;
  sli_pkg::sli_ind_t next_ind;

  always_comb begin
    next_ind = sli_pkg::IND_RESET;
    next_ind.buzzer_output = next_tone_lvl; // R11
    case (op_state_i) // R18
      sli_pkg::SLI_ST_STANDBY: begin // R5
        next_ind.green_led_output = standby_lit; // R1 R6 R7
        next_ind.red_led_output   = standby_lit; // R2 R6 R7
      end
      sli_pkg::SLI_ST_TRANSFER: begin
        next_ind.green_led_output = slow_on; // R3
      end
      sli_pkg::SLI_ST_COMPLETE: begin
        next_ind.green_led_output = 1'b1; // R3
      end
      sli_pkg::SLI_ST_FAULT: begin
        next_ind.red_led_output = 1'b1; // R4
      end
      sli_pkg::SLI_ST_FOA_WARN: begin
        next_ind.red_led_output = fast_on; // R4 R16
      end
      default: begin
        next_ind.red_led_output = 1'b1;
      end
    endcase
    // LED and buzzer outputs held off until the strap is known
    if (!opt_valid) begin // R5
      next_ind = sli_pkg::IND_RESET;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ind <= sli_pkg::IND_RESET;
    end else begin
      ind <= next_ind;
    end
  end

  assign green_led_output_o = ind.green_led_output;
  assign red_led_output_o   = ind.red_led_output;
  assign buzzer_output_o    = ind.buzzer_output;
  assign led_option_o       = option;

endmodule

// ----------------------------------------------------------------
// Wrapping period counter
// ----------------------------------------------------------------
// Next count exported so callers act on the edge the count restarts
module sli_wrap_cnt #(
  parameter int unsigned PERIOD = 2,
  parameter int unsigned W      = $clog2(PERIOD) + 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         clear_i,
  input  wire logic         run_i,
  output logic [W-1:0]      next_o,
  output logic              wrap_o
);
  logic [W-1:0] cnt;

  always_comb begin
    wrap_o = run_i && !clear_i && (cnt == W'(PERIOD - 1));
    next_o = cnt;
    if (clear_i || wrap_o) begin
      next_o = '0;
    end else if (run_i) begin
      next_o = cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_o;
    end
  end
endmodule

// >>> sli_strap_model.sv
// Model of the option strap resistor network
`timescale 1ns/100ps
module sli_strap_model (
  input  wire logic       hold_i,
  input  wire logic [3:0] code_i,
  output logic [3:0]      strap_o
);
  // Level wanders after capture; inverse exposes a late re-read
  assign strap_o = hold_i ? code_i : ~code_i;
endmodule

// >>> sli_indicator_sva.sv
// Checker for indicator patterns and tone timing
`timescale 1ns/100ps
module sli_indicator_sva #(
  parameter int unsigned TONE_HALF_CYC = 4
) (
  input wire logic                   clk_i,
  input wire logic                   nrst_i,
  input wire sli_pkg::sli_op_state_t op_state_i,
  input wire logic [3:0]             strap_level_i,
  input wire logic                   green_led_output_o,
  input wire logic                   red_led_output_o,
  input wire logic                   buzzer_output_o,
  input wire logic [3:0]             led_option_o
);
  localparam int TONE_WAIT = TONE_HALF_CYC + 2;
  logic [2:0]  rel;
  logic [2:0]  next_rel;
  logic [15:0] hi_cnt;
  logic [15:0] next_hi_cnt;
  logic        en;
  // Internal reset lags the pin, so skip the first cycles
  always_comb begin
    next_rel    = (rel == 3'h7) ? rel : rel + 3'h1;
    next_hi_cnt = buzzer_output_o ? hi_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rel    <= 3'h0;
      hi_cnt <= 16'h0000;
    end else begin
      rel    <= next_rel;
      hi_cnt <= next_hi_cnt;
    end
  end
  assign en = (rel == 3'h7);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  fault_red_a: assert property (en && $past(op_state_i) == sli_pkg::SLI_ST_FAULT
    |-> red_led_output_o && !green_led_output_o) else $error("fault pattern wrong");
  complete_green_a: assert property (en && $past(op_state_i) == sli_pkg::SLI_ST_COMPLETE
    |-> green_led_output_o && !red_led_output_o) else $error("complete pattern wrong");
  standby_pair_a: assert property (en && $past(op_state_i) == sli_pkg::SLI_ST_STANDBY
    |-> green_led_output_o == red_led_output_o
    && green_led_output_o == (led_option_o < sli_pkg::OPT_FIRST_DARK)) else $error("standby pattern wrong");
  option_held_a: assert property (en |-> $stable(led_option_o)) else $error("option changed");
  quiet_buzzer_a: assert property (en && $past(op_state_i) inside {sli_pkg::SLI_ST_STANDBY,
    sli_pkg::SLI_ST_COMPLETE, sli_pkg::SLI_ST_FAULT} |-> !buzzer_output_o) else $error("stray tone");
  tone_half_a: assert property (en && $fell(buzzer_output_o)
    |-> hi_cnt == 16'(TONE_HALF_CYC)) else $error("tone half period wrong");
  note_start_a: assert property (en && op_state_i == sli_pkg::SLI_ST_TRANSFER
    && $past(op_state_i) != sli_pkg::SLI_ST_TRANSFER |-> ##1 green_led_output_o ##[0:TONE_WAIT] buzzer_output_o)
    else $error("transfer start wrong");
  warn_entry_a: assert property (en && op_state_i == sli_pkg::SLI_ST_FOA_WARN
    && $past(op_state_i) != sli_pkg::SLI_ST_FOA_WARN |-> ##1 red_led_output_o[*8]) else $error("warning start wrong");
  warn_sync_a: assert property (en && $past(op_state_i) == sli_pkg::SLI_ST_FOA_WARN && buzzer_output_o
    |-> red_led_output_o) else $error("tone without red");
endmodule

// >>> sli_indicator_tb.sv
// Testbench for the status LED and buzzer indicator
`timescale 1ns/100ps
module sli_indicator_tb;
  logic                   clk_i = 1'b0;
  logic                   nrst_i = 1'b0;
  sli_pkg::sli_op_state_t op_state_i = sli_pkg::SLI_ST_STANDBY;
  logic                   hold = 1'b1;
  logic [3:0]             code = 4'h0;
  logic [3:0]             strap_level_i;
  logic                   green;
  logic                   red;
  logic                   buzz;
  logic [3:0]             opt;
  logic [15:0]            n_g;
  logic [15:0]            n_r;
  logic [15:0]            n_b;
  int                     n_errors = 0;
  int                     checks_done = 0;
  always #5 clk_i = ~clk_i;
  sli_strap_model strap_u (.hold_i(hold), .code_i(code), .strap_o(strap_level_i));
  // Short counts keep the run brief; expectations scale with them
  // On times follow from the periods by the fixed duty dividers
  sli_indicator #(.SLOW_PERIOD_CYC(200), .NOTE_CYC(40), .FOA_PERIOD_CYC(120), .FOA_PHASES(3),
    .TONE_HALF_CYC(4)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .op_state_i(op_state_i), .strap_level_i(strap_level_i), .green_led_output_o(green),
    .red_led_output_o(red), .buzzer_output_o(buzz), .led_option_o(opt));
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Counts LED high cycles and tone rising edges over n cycles
  task automatic count(input int n);
    logic prev;
    n_g = 16'h0000;
    n_r = 16'h0000;
    n_b = 16'h0000;
    prev = buzz;
    repeat (n) begin
      tick(1);
      n_g = n_g + 16'(green === 1'b1);
      n_r = n_r + 16'(red === 1'b1);
      n_b = n_b + 16'(buzz === 1'b1 && prev === 1'b0);
      prev = buzz;
    end
  endtask
  task automatic strap_scan;
    for (int c = 0; c < 11; c++) begin
      hold = 1'b1;
      code = (c < 10) ? 4'(c) : 4'hF;
      nrst_i = 1'b0;
      tick(6);
      nrst_i = 1'b1;
      tick(5);
      cmp(16'(opt), (c < 10) ? 16'(c + 1) : 16'h000A);
      hold = 1'b0;
      tick(3);
      cmp(16'(opt), (c < 10) ? 16'(c + 1) : 16'h000A);
      cmp(16'({green, red}), (c < 5) ? 16'h0003 : 16'h0000);
    end
  endtask
  task automatic transfer_run;
    op_state_i = sli_pkg::SLI_ST_TRANSFER;
    count(300);
    cmp(n_g, 16'h00C8);
    cmp(n_r, 16'h0000);
    cmp(n_b, 16'h0005);
  endtask
  task automatic steady_run;
    op_state_i = sli_pkg::SLI_ST_COMPLETE;
    count(50);
    cmp({n_g[7:0], n_r[3:0], n_b[3:0]}, 16'h3200);
    op_state_i = sli_pkg::SLI_ST_FAULT;
    count(50);
    cmp({n_g[3:0], n_r[7:0], n_b[3:0]}, 16'h0320);
    op_state_i = sli_pkg::sli_op_state_t'(3'h7);
    count(50);
    cmp({n_g[3:0], n_r[7:0], n_b[3:0]}, 16'h0320);
  endtask
  task automatic warn_run;
    op_state_i = sli_pkg::SLI_ST_FOA_WARN;
    count(360);
    cmp({n_g[3:0], n_r[7:0], n_b[3:0]}, 16'h078F);
    count(360);
    cmp({n_g[3:0], n_r[7:0], n_b[3:0]}, 16'h0780);
    count(360);
    cmp(n_b, 16'h000F);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    strap_scan();
    transfer_run();
    steady_run();
    warn_run();
    close_out();
  end
endmodule
bind sli_indicator sli_indicator_sva #(.TONE_HALF_CYC(TONE_HALF_CYC)) chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
  .op_state_i(op_state_i), .strap_level_i(strap_level_i), .green_led_output_o(green_led_output_o),
  .red_led_output_o(red_led_output_o), .buzzer_output_o(buzzer_output_o), .led_option_o(led_option_o));
